// ===== logic/dbgef_pkg.sv
// Purpose: shared constants and carriers for the debug access error flags
// Assumes: one core clock, synchronous active-high reset
// Notes: status_low_register bit positions and filler byte live here
package dbgef_pkg;
	localparam int          STAT_W        = 8;
	localparam int          BIT_COLLIDE   = 4;
	localparam int          BIT_ACCESS_INCOMPLETE_FLAG    = 3;
	localparam int          BIT_RDBAD     = 2;
	localparam int          BIT_ILLEGAL   = 1;
	localparam logic [7:0]  FILLER_BYTE   = 8'hEE;
	localparam logic [7:0]  STAT_RESET    = 8'h00;
	localparam int          FREE_WAIT_CYC = 512;
	localparam int          WAIT_CNT_W    = 10;
	localparam logic [9:0]  WAIT_ONE      = 10'h001;
	localparam logic [9:0]  WAIT_ZERO     = 10'h000;

	// events reported by the command/access engine, one-cycle pulses
	typedef struct packed {
		logic new_cmd;
		logic cmd_busy;
		logic host_low_ack;
		logic calib_pulse;
		logic read_start;
		logic acc_busy;
		logic wr_busy;
		logic stop_access;
		logic bg_cmd;
		logic reg_cmd;
		logic step_cmd;
		logic ecc_err;
		logic unimpl_addr;
		logic flash_write;
		logic bad_reg_index;
	} dbgef_evt_t;

	// device mode levels
	typedef struct packed {
		logic ack_en;
		logic grab_en;
		logic stop_mode;
		logic wait_mode;
		logic wait_return;
		logic entering_wait;
		logic ctrl_en;
		logic stop_continue_select;
		logic external_stall;
	} dbgef_mode_t;

	typedef enum logic [2:0] {
		ACC_IDLE  = 3'b001,
		ACC_WAIT  = 3'b010,
		ACC_ABORT = 3'b100
	} dbgef_acc_state_t;
endpackage

// ===== logic/dbgef_sticky.sv
// Purpose: one sticky flag with write-one clear
// Assumes: set and clear are same-clock pulses
// Notes: set beats clear in the same cycle
`timescale 1ns/1ps
module dbgef_sticky (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// control
	input  wire logic set_req,
	input  wire logic clr_req,
	// state
	output logic      flag_q
);
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			flag_q <= 1'b0;
		else if (set_req)
			flag_q <= 1'b1;
		else if (clr_req)
			flag_q <= 1'b0;
	end
endmodule

// ===== logic/dbgef_core.sv
// Purpose: error flags of the debug status low register, access abort and filler data
// Assumes: event pulses come from the command engine on ref_clk; debug_pin is raw
// Notes: wait, stop and write-fault bits are not kept here and read as zero
//
// Functional notes
// - new command before current one completes sets collision flag
// - with ack enabled, host driving pin low during pending ack sets collision
// - collision flag suppresses internal accesses; only calibration pulse clears it
// - ack on, grab off: no free cycle within 512 clocks sets incomplete
// - ack off or grab on: unfinished access at read or next command sets incomplete
// - stop-mode memory or pc sample with select clear sets incomplete
// - incomplete flag aborts access, but not while external stall held
// - background request in wait mode sets incomplete, not aborted, completes later
// - each core register command in wait mode sets incomplete again
// - any command while returning from wait sets incomplete
// - step command while entering wait sets incomplete regardless of halt state
// - incomplete flag set returns filler 0xEE for every data byte
// - incomplete, corrupt read, illegal flags clear on host write one
// - ecc error on debug read sets corrupt flag, real data returned
// - unimplemented memory, flash write, bad register index set illegal flag
// - illegal access returns filler 0xEE per data byte
// - ack command setting bits 3..1 answers with long ack
// - after pin-low collision, acks stay long while flag set
// - host writes to collision position have no effect
`timescale 1ns/1ps
module dbgef_core
	import dbgef_pkg::*;
#(
	parameter int FREE_WAIT = FREE_WAIT_CYC
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// debug pin, raw
	input  wire logic        debug_pin,
	// engine events and modes
	input  wire dbgef_evt_t  evt,
	input  wire dbgef_mode_t mode,
	input  wire logic        ack_pending,
	input  wire logic        ack_cmd_done,
	// internal access engine
	input  wire logic        acc_req,
	input  wire logic        free_cycle,
	input  wire logic        acc_done,
	input  wire logic [7:0]  rd_data,
	input  wire logic        rd_valid,
	// host write to status low register
	input  wire logic        stat_wr,
	input  wire logic [7:0]  stat_wdata,
	// outputs to engine
	output logic             acc_go,
	output logic             acc_abort,
	output logic             bg_hold,
	output logic             long_ack,
	output logic [7:0]       data_out_q,
	output logic [7:0]       status_low_register
);
	logic             pin_s1_q;
	logic             pin_s2_q;
	logic             pin_low;
	logic             collide_q;
	logic             access_incomplete_flag_q;
	logic             rdbad_q;
	logic             illegal_q;
	logic             pin_collide_q;
	logic             pin_collide_d;
	logic             bg_hold_q;
	logic             bg_hold_d;
	logic [9:0]       wait_cnt_q;
	logic [9:0]       wait_cnt_d;
	dbgef_acc_state_t st_q;
	dbgef_acc_state_t st_d;

	// pin is asynchronous to the core clock
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end else begin
			pin_s1_q <= debug_pin;
			pin_s2_q <= pin_s1_q;
		end
	end
	assign pin_low = ~pin_s2_q;

	// collision set terms
	wire collide_cmd  = evt.new_cmd & evt.cmd_busy;
	wire collide_pin  = mode.ack_en & ack_pending & pin_low;
	wire collide_set  = collide_cmd | collide_pin;

	// incomplete set terms
	wire handshake    = mode.ack_en & ~mode.grab_en;
	wire timeout_hit  = (st_q == ACC_WAIT) && (wait_cnt_q == 10'(FREE_WAIT - 1));
	wire access_incomplete_flag_tmo   = handshake & timeout_hit & ~free_cycle;
	wire access_incomplete_flag_late  = ~handshake &
		((evt.read_start & evt.acc_busy) | (evt.new_cmd & evt.wr_busy));
	wire access_incomplete_flag_stop  = mode.stop_mode & ~mode.stop_continue_select & evt.stop_access;
	wire access_incomplete_flag_bg    = mode.wait_mode & evt.bg_cmd;
	wire access_incomplete_flag_reg   = mode.wait_mode & evt.reg_cmd;
	wire access_incomplete_flag_ret   = mode.wait_return & evt.new_cmd;
	wire access_incomplete_flag_step  = mode.ctrl_en & mode.entering_wait & evt.step_cmd;
	wire access_incomplete_flag_set   = access_incomplete_flag_tmo | access_incomplete_flag_late | access_incomplete_flag_stop | access_incomplete_flag_bg |
		access_incomplete_flag_reg | access_incomplete_flag_ret | access_incomplete_flag_step;

	wire rdbad_set    = evt.ecc_err;
	wire illegal_set  = evt.unimpl_addr | evt.flash_write | evt.bad_reg_index;

	// write-one clears; collision position ignores writes
	wire clr_access_incomplete_flag   = stat_wr & stat_wdata[BIT_ACCESS_INCOMPLETE_FLAG];
	wire clr_rdbad    = stat_wr & stat_wdata[BIT_RDBAD];
	wire clr_illegal  = stat_wr & stat_wdata[BIT_ILLEGAL];

	dbgef_sticky u_collide (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.set_req (collide_set),
		.clr_req (evt.calib_pulse),
		.flag_q  (collide_q)
	);
	dbgef_sticky u_access_incomplete_flag (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.set_req (access_incomplete_flag_set),
		.clr_req (clr_access_incomplete_flag),
		.flag_q  (access_incomplete_flag_q)
	);
	dbgef_sticky u_rdbad (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.set_req (rdbad_set),
		.clr_req (clr_rdbad),
		.flag_q  (rdbad_q)
	);
	dbgef_sticky u_illegal (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.set_req (illegal_set),
		.clr_req (clr_illegal),
		.flag_q  (illegal_q)
	);

	// pin-caused collision keeps acks long until calibration
	// set wins like the flag itself, so the two never disagree
	assign pin_collide_d = collide_pin ? 1'b1 :
		(evt.calib_pulse ? 1'b0 : pin_collide_q);

	// background request held through wait mode instead of aborting
	assign bg_hold_d = access_incomplete_flag_bg ? 1'b1 : (mode.wait_mode ? bg_hold_q : 1'b0);

	// access sequencer: waits for a free cycle in handshake mode, aborts when allowed
	wire suppress     = collide_q | collide_set;
	wire want_abort   = access_incomplete_flag_set & ~access_incomplete_flag_bg;
	always_comb begin
		st_d       = st_q;
		wait_cnt_d = wait_cnt_q;
		unique case (st_q)
			ACC_IDLE: begin
				wait_cnt_d = WAIT_ZERO;
				if (acc_req && !suppress) begin
					st_d = ACC_WAIT;
				end
			end
			ACC_WAIT: begin
				if (acc_done || suppress) begin
					st_d = ACC_IDLE;
				end else if (want_abort) begin
					st_d = ACC_ABORT;
				end else if (handshake && !free_cycle) begin
					wait_cnt_d = wait_cnt_q + WAIT_ONE;
				end
			end
			ACC_ABORT: begin
				// external stall must drop before the abort may finish
				if (!mode.external_stall) begin
					st_d = ACC_IDLE;
				end
			end
			default: begin
				st_d = ACC_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q          <= ACC_IDLE;
			wait_cnt_q    <= WAIT_ZERO;
			pin_collide_q <= 1'b0;
			bg_hold_q     <= 1'b0;
		end else begin
			st_q          <= st_d;
			wait_cnt_q    <= wait_cnt_d;
			pin_collide_q <= pin_collide_d;
			bg_hold_q     <= bg_hold_d;
		end
	end

	assign acc_go    = (st_q == ACC_WAIT) & ~suppress &
		(free_cycle | ~handshake);
	assign acc_abort = (st_q == ACC_ABORT) & ~mode.external_stall;
	assign bg_hold   = bg_hold_q;

	// long ack: bits 3..1 already set or raised by this command, or pin collision still pending
	wire err_now = access_incomplete_flag_set | rdbad_set | illegal_set;
	assign long_ack = mode.ack_en & ack_cmd_done &
		(err_now | access_incomplete_flag_q | illegal_q | rdbad_q | (pin_collide_q & collide_q));

	// filler replaces data; ecc errors still pass the real byte
	wire fill = access_incomplete_flag_q | access_incomplete_flag_set | illegal_q | illegal_set;
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			data_out_q <= STAT_RESET;
		else if (rd_valid)
			data_out_q <= fill ? FILLER_BYTE : rd_data;
	end

	always_comb begin
		status_low_register              = STAT_RESET;
		status_low_register[BIT_COLLIDE] = collide_q;
		status_low_register[BIT_ACCESS_INCOMPLETE_FLAG]  = access_incomplete_flag_q;
		status_low_register[BIT_RDBAD]   = rdbad_q;
		status_low_register[BIT_ILLEGAL] = illegal_q;
	end
endmodule

// ===== testbench/dbgef_core_checker.sv
// Purpose: assertions on the debug access error flags
// Assumes: one clock, sync active-high reset
// Notes: bound to dbgef_core
`timescale 1ns/1ps
module dbgef_core_checker
	import dbgef_pkg::*;
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// inputs
	input wire dbgef_evt_t  evt,
	input wire dbgef_mode_t mode,
	input wire logic        acc_req,
	input wire logic [7:0]  rd_data,
	input wire logic        rd_valid,
	input wire logic        stat_wr,
	input wire logic [7:0]  stat_wdata,
	// outputs
	input wire logic        acc_go,
	input wire logic        acc_abort,
	input wire logic [7:0]  data_out_q,
	input wire logic [7:0]  status_low_register
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire logic [7:0] st = status_low_register;
	wire logic ill = evt.unimpl_addr | evt.flash_write | evt.bad_reg_index;
	coll_set_a: assert property (evt.new_cmd && evt.cmd_busy |=> st[4])
		else $error("collision flag not set");
	coll_keep_a: assert property (st[4] && !evt.calib_pulse |=> st[4])
		else $error("collision flag lost");
	go_block_a: assert property (st[4] |-> !acc_go) else $error("access not held off");
	abort_stall_a: assert property (mode.external_stall |-> !acc_abort)
		else $error("abort during stall");
	rdbad_set_a: assert property (evt.ecc_err |=> st[2]) else $error("corrupt flag not set");
	ill_set_a: assert property (ill |=> st[1]) else $error("illegal flag not set");
	filler_a: assert property (rd_valid && (st[3] || st[1]) |=> data_out_q == FILLER_BYTE)
		else $error("filler byte missing");
	real_data_a: assert property (rd_valid && !st[3] && !st[1] && evt == '0 && !acc_req
		|=> data_out_q == $past(rd_data)) else $error("read data altered");
	w1c_a: assert property (stat_wr && stat_wdata[2] && !evt.ecc_err |=> !st[2])
		else $error("flag not cleared");
	set_wins_a: assert property (stat_wr && stat_wdata[1] && ill |=> st[1])
		else $error("clear beat set");
endmodule
bind dbgef_core dbgef_core_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .evt(evt),
	.mode(mode), .acc_req(acc_req), .rd_data(rd_data), .rd_valid(rd_valid),
	.stat_wr(stat_wr), .stat_wdata(stat_wdata), .acc_go(acc_go), .acc_abort(acc_abort),
	.data_out_q(data_out_q), .status_low_register(status_low_register));

// ===== testbench/dbgef_host.sv
// Purpose: host debugger model on the debug pin
// Assumes: pin has a pull-up
// Notes: released pin returns to the pull-up level
`timescale 1ns/1ps
module dbgef_host (
	// request
	input  wire logic pull_low,
	// pin
	output logic      debug_pin
);
	assign debug_pin = pull_low ? 1'b0 : 1'b1;
endmodule

// ===== testbench/dbgef_core_bench.sv
// Purpose: self-checking bench for the debug access error flags
// Assumes: inputs driven at falling edge
// Notes: short access timeout for run time
`timescale 1ns/1ps
module dbgef_core_bench;
	import dbgef_pkg::*;
	localparam int FW = 8;
	logic ref_clk = 0, sys_rst = 1, pull = 0, ack_pending = 0, acc_req = 0, free_cycle = 0;
	logic rd_valid = 0, stat_wr = 0, acc_go, acc_abort, bg_hold, long_ack, debug_pin;
	logic acc_done = 0, ack_cmd_done = 0;
	logic [7:0] rd_data = 0, stat_wdata = 0, data_out_q, st;
	dbgef_evt_t evt = '0;
	dbgef_mode_t mode = '0;
	int fail_count = 0, comparisons = 0, cyc = 0;
	dbgef_host host (.pull_low(pull), .debug_pin(debug_pin));
	dbgef_core #(.FREE_WAIT(FW)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.debug_pin(debug_pin), .evt(evt), .mode(mode), .ack_pending(ack_pending),
		.ack_cmd_done(ack_cmd_done), .acc_req(acc_req), .free_cycle(free_cycle),
		.acc_done(acc_done),
		.rd_data(rd_data), .rd_valid(rd_valid), .stat_wr(stat_wr), .stat_wdata(stat_wdata),
		.acc_go(acc_go), .acc_abort(acc_abort), .bg_hold(bg_hold), .long_ack(long_ack),
		.data_out_q(data_out_q), .status_low_register(st));
	initial forever #20 ref_clk = ~ref_clk;
	task chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one edge passes; pulses drop afterwards
	task nxt;
		@(negedge ref_clk);
		evt = '0;
		rd_valid = 0;
		stat_wr = 0;
		acc_done = 0;
		ack_cmd_done = 0;
	endtask
	task end_sim;
		$display("compares %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task t_coll;
		evt.new_cmd = 1;
		evt.cmd_busy = 1;
		nxt;
		chk(st, 8'h10);
		acc_req = 1;
		free_cycle = 1;
		stat_wr = 1;
		stat_wdata = 8'hFF;
		nxt;
		chk(st, 8'h10);
		chk({7'h00, acc_go}, 8'h00);
		evt.calib_pulse = 1;
		nxt;
		chk(st, 8'h00);
		nxt;
		chk({7'h00, acc_go}, 8'h01);
		acc_req = 0;
		acc_done = 1;
		nxt;
		$display("collision test done");
	endtask
	task t_pin;
		mode.ack_en = 1;
		ack_pending = 1;
		pull = 1;
		repeat (4) nxt;
		chk(st, 8'h10);
		pull = 0;
		ack_pending = 0;
		evt.calib_pulse = 1;
		nxt;
		chk(st, 8'h00);
		$display("pin test done");
	endtask
	task t_wait;
		mode.external_stall = 1;
		acc_req = 1;
		free_cycle = 0;
		repeat (FW) nxt;
		chk(st, 8'h00);
		nxt;
		chk(st, 8'h08);
		rd_valid = 1;
		rd_data = 8'h5A;
		nxt;
		chk(data_out_q, FILLER_BYTE);
		chk({7'h00, acc_abort}, 8'h00);
		mode.external_stall = 0;
		acc_req = 0;
		#1 chk({7'h00, acc_abort}, 8'h01);
		stat_wr = 1;
		stat_wdata = 8'h08;
		nxt;
		chk(st, 8'h00);
		$display("timeout test done");
	endtask
	task t_read;
		rd_valid = 1;
		rd_data = 8'hA5;
		nxt;
		chk(data_out_q, 8'hA5);
		evt.ecc_err = 1;
		rd_valid = 1;
		rd_data = 8'h5A;
		nxt;
		chk(data_out_q, 8'h5A);
		chk(st, 8'h04);
		stat_wr = 1;
		stat_wdata = 8'h04;
		nxt;
		chk(st, 8'h00);
		$display("read test done");
	endtask
	task t_ill;
		for (int i = 0; i < 3; i++) begin
			evt.unimpl_addr = (i == 0);
			evt.flash_write = (i == 1);
			evt.bad_reg_index = (i == 2);
			rd_valid = 1;
			stat_wr = 1;
			stat_wdata = 8'h02;
			nxt;
			chk(data_out_q, FILLER_BYTE);
			chk(st, 8'h02);
			stat_wr = 1;
			nxt;
			chk(st, 8'h00);
		end
		$display("illegal test done");
	endtask
	task t_ack;
		mode = '0;
		mode.ack_en = 1;
		ack_cmd_done = 1;
		#1 chk({7'h00, long_ack}, 8'h00);
		nxt;
		evt.flash_write = 1;
		ack_cmd_done = 1;
		#1 chk({7'h00, long_ack}, 8'h01);
		nxt;
		stat_wr = 1;
		stat_wdata = 8'h02;
		nxt;
		chk(st, 8'h00);
		ack_pending = 1;
		pull = 1;
		repeat (3) nxt;
		chk(st, 8'h10);
		ack_pending = 0;
		pull = 0;
		ack_cmd_done = 1;
		#1 chk({7'h00, long_ack}, 8'h01);
		nxt;
		evt.calib_pulse = 1;
		nxt;
		ack_cmd_done = 1;
		#1 chk({7'h00, long_ack}, 8'h00);
		nxt;
		$display("ack test done");
	endtask
	task t_modes;
		for (int i = 0; i < 7; i++) begin
			mode = '0;
			case (i)
				0: begin
					evt.read_start = 1;
					evt.acc_busy = 1;
				end
				1: begin
					evt.new_cmd = 1;
					evt.wr_busy = 1;
				end
				2: begin
					mode.stop_mode = 1;
					evt.stop_access = 1;
				end
				3: begin
					mode.wait_mode = 1;
					evt.reg_cmd = 1;
				end
				4: begin
					mode.wait_mode = 1;
					evt.bg_cmd = 1;
				end
				5: begin
					mode.wait_return = 1;
					evt.new_cmd = 1;
				end
				default: begin
					mode.ctrl_en = 1;
					mode.entering_wait = 1;
					evt.step_cmd = 1;
				end
			endcase
			nxt;
			chk(st, 8'h08);
			chk({7'h00, bg_hold}, {7'h00, i == 4});
			stat_wr = 1;
			stat_wdata = 8'h08;
			nxt;
			chk(st, 8'h00);
		end
		mode = '0;
		mode.stop_mode = 1;
		mode.stop_continue_select = 1;
		evt.stop_access = 1;
		nxt;
		chk(st, 8'h00);
		$display("mode test done");
	endtask
	// hang guard, well above the run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			end_sim;
		end
	end
	initial begin
		repeat (10) @(negedge ref_clk);
		sys_rst = 0;
		nxt;
		t_coll;
		t_pin;
		t_wait;
		t_read;
		t_ill;
		t_ack;
		t_modes;
		end_sim;
	end
endmodule
